// *** pkg/bbcs_map.vh ***
`ifndef BBCS_MAP_VH
`define BBCS_MAP_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BBCS_CLK_HZ        25000000
`define BBCS_OFF_MS        500
`define BBCS_OFF_CYC       ((`BBCS_CLK_HZ / 1000) * `BBCS_OFF_MS)
`define BBCS_MULT_DEF      2

// ----------------------------------------------------------------
// colour codes
// ----------------------------------------------------------------
`define BBCS_COL_OFF       3'h0
`define BBCS_COL_RED       3'h1
`define BBCS_COL_GREEN     3'h2
`define BBCS_COL_BLUE      3'h3
`define BBCS_COL_AMBER     3'h4
`define BBCS_COL_LBLUE     3'h5
`define BBCS_COL_MAGENTA   3'h6
`define BBCS_COL_WHITE     3'h7

// rgb enable bit positions
`define BBCS_RGB_R         2
`define BBCS_RGB_G         1
`define BBCS_RGB_B         0

`endif

// *** hdl/bbcs_color_map.v ***
`timescale 1ns/1ps
`include "bbcs_map.vh"

module bbcs_color_map (
  // colour select
  input  wire [2:0] colorSel,
  // rgb enables
  output reg  [2:0] rgb
);

  always @* begin
    case (colorSel)
      `BBCS_COL_OFF:     rgb = 3'h0;
      `BBCS_COL_RED:     rgb = 3'h4;
      `BBCS_COL_GREEN:   rgb = 3'h2;
      `BBCS_COL_BLUE:    rgb = 3'h1;
      `BBCS_COL_AMBER:   rgb = 3'h6;
      `BBCS_COL_LBLUE:   rgb = 3'h3;
      `BBCS_COL_MAGENTA: rgb = 3'h5;
      `BBCS_COL_WHITE:   rgb = 3'h7;
      default:           rgb = 3'h0;
    endcase
  end

endmodule

// *** hdl/bbcs_sequencer.v ***
`timescale 1ns/1ps
`include "bbcs_map.vh"

module bbcs_sequencer #(
  parameter CNT_W   = 32,
  parameter MULT_W  = 4,
  parameter OFF_CYC = `BBCS_OFF_CYC
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // configuration from firmware
  input  wire              cfgLoad,
  input  wire [CNT_W-1:0]  cfgOffLen,
  input  wire [MULT_W-1:0] cfgMult,
  input  wire [2:0]        cfgOnColor,
  input  wire [2:0]        cfgOffColor,
  // backlight drive
  output reg               ledRed,
  output reg               ledGreen,
  output reg               ledBlue,
  output reg               onPhase
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam                    ST_ON      = 2'b01;
  localparam                    ST_OFF     = 2'b10;

  localparam integer            MULT_DEF_I = `BBCS_MULT_DEF;
  localparam [CNT_W-1:0]        OFF_DEF    = OFF_CYC;
  localparam [MULT_W-1:0]       MULT_DEF   = MULT_DEF_I[MULT_W-1:0];
  localparam [CNT_W+MULT_W-1:0] ON_DEF_W   = OFF_DEF * MULT_DEF;
  localparam [CNT_W-1:0]        ON_DEF     = ON_DEF_W[CNT_W-1:0];
  localparam [CNT_W-1:0]        CNT_ZERO   = {CNT_W{1'b0}};
  localparam [CNT_W-1:0]        CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [MULT_W-1:0]       MULT_ZERO  = {MULT_W{1'b0}};
  localparam [MULT_W-1:0]       MULT_ONE   = {{(MULT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [1:0]              state;
  reg  [CNT_W-1:0]        count;
  reg  [CNT_W-1:0]        offLen;
  reg  [MULT_W-1:0]       mult;
  reg  [CNT_W-1:0]        onLen;
  reg  [2:0]              onColor;
  reg  [2:0]              offColor;
  reg  [1:0]              next_state;
  reg  [CNT_W-1:0]        next_count;
  reg  [CNT_W-1:0]        next_offLen;
  reg  [MULT_W-1:0]       next_mult;
  reg  [2:0]              next_onColor;
  reg  [2:0]              next_offColor;
  reg  [CNT_W-1:0]        next_onLen;
  reg                     next_ledRed;
  reg                     next_ledGreen;
  reg                     next_ledBlue;
  reg                     next_onPhase;
  wire                    onLast;
  wire                    offLast;
  wire                    prodOver;
  wire [2:0]              curColor;
  wire [2:0]              rgb;
  wire [CNT_W+MULT_W-1:0] prod;

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  // zero values would stall the phase; a zero off length becomes one cycle, a zero mult becomes one
  always @* begin
    next_offLen   = offLen;
    next_mult     = mult;
    next_onColor  = onColor;
    next_offColor = offColor;
    if (cfgLoad) begin
      if (cfgOffLen == CNT_ZERO) begin
        next_offLen = CNT_ONE;
      end else begin
        next_offLen = cfgOffLen;
      end
      if (cfgMult == MULT_ZERO) begin
        next_mult = MULT_ONE;
      end else begin
        next_mult = cfgMult;
      end
      next_onColor  = cfgOnColor;
      next_offColor = cfgOffColor;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      offLen <= OFF_DEF;
    end else begin
      offLen <= next_offLen;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      mult <= MULT_DEF;
    end else begin
      mult <= next_mult;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      onColor <= `BBCS_COL_WHITE;
    end else begin
      onColor <= next_onColor;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      offColor <= `BBCS_COL_OFF;
    end else begin
      offColor <= next_offColor;
    end
  end

  // ----------------------------------------------------------------
  // on length
  // ----------------------------------------------------------------
  // registered to keep the multiplier off the count path, so a new
  // on length lands one cycle after the load
  assign prod     = offLen * mult;
  // an overflowing product saturates instead of wrapping to a short
  // or zero length
  assign prodOver = |prod[CNT_W+MULT_W-1:CNT_W];

  always @* begin
    if (prodOver) begin
      next_onLen = {CNT_W{1'b1}};
    end else begin
      next_onLen = prod[CNT_W-1:0];
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      onLen <= ON_DEF;
    end else begin
      onLen <= next_onLen;
    end
  end

  // ----------------------------------------------------------------
  // phase machine
  // ----------------------------------------------------------------
  // >= so that a length shortened mid-phase ends the phase at once
  assign onLast  = (count >= onLen - CNT_ONE);
  assign offLast = (count >= offLen - CNT_ONE);

  always @* begin
    next_state = state;
    next_count = count + CNT_ONE;
    case (state)
      ST_ON: begin
        if (onLast) begin
          next_state = ST_OFF;
          next_count = CNT_ZERO;
        end
      end
      ST_OFF: begin
        if (offLast) begin
          next_state = ST_ON;
          next_count = CNT_ZERO;
        end
      end
      default: begin
        next_state = ST_ON;
        next_count = CNT_ZERO;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_ON;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      count <= CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // colour output
  // ----------------------------------------------------------------
  assign curColor = (state == ST_OFF) ? offColor : onColor;

  bbcs_color_map u_map (
    .colorSel (curColor),
    .rgb      (rgb)
  );

  // one register stage for all four, so colour and phase flag
  // never disagree by a cycle
  always @* begin
    next_ledRed   = rgb[`BBCS_RGB_R];
    next_ledGreen = rgb[`BBCS_RGB_G];
    next_ledBlue  = rgb[`BBCS_RGB_B];
    next_onPhase  = (state == ST_ON);
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      ledRed   <= 1'b0;
      ledGreen <= 1'b0;
      ledBlue  <= 1'b0;
      onPhase  <= 1'b0;
    end else begin
      ledRed   <= next_ledRed;
      ledGreen <= next_ledGreen;
      ledBlue  <= next_ledBlue;
      onPhase  <= next_onPhase;
    end
  end

endmodule

// *** dv/bbcs_properties.sv ***
`timescale 1ns/1ps
module bbcs_properties #(parameter OFF_CYC = 10) (
  // clock and reset
  input logic       clk_sys,
  input logic       rst,
  // configuration
  input logic       cfgLoad,
  input logic [2:0] cfgOnColor,
  input logic [2:0] cfgOffColor,
  // backlight drive
  input logic       ledRed,
  input logic       ledGreen,
  input logic       ledBlue,
  input logic       onPhase
);
  localparam [23:0] LUT = 24'hf5e2a0;
  logic        cfgSeen, ranOn;
  logic [2:0]  onCol, offCol;
  logic [31:0] runLen;
  wire  [2:0]  rgb = {ledRed, ledGreen, ledBlue};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always @(posedge clk_sys) begin
    if (rst) begin
      {cfgSeen, ranOn, onCol, offCol} <= 8'h38;
      runLen <= 32'h0;
    end else begin
      runLen <= $changed(onPhase) ? 32'h1 : runLen + 32'h1;
      ranOn <= ranOn | onPhase;
      if (cfgLoad)
        {cfgSeen, onCol, offCol} <= {1'b1, cfgOnColor, cfgOffColor};
    end
  end
  // lengths judged only while defaults hold; loads cut runs short
  sequence sFall; onPhase ##1 !onPhase; endsequence
  sequence sRise; !onPhase ##1 onPhase; endsequence
  AST_RESET_OUT: assert property (disable iff (1'b0) rst |=> rgb == 3'h0 && !onPhase)
    else $error("outputs active in reset");
  AST_START_ON: assert property ($fell(rst) |-> ##[0:2] onPhase)
    else $error("no on phase after reset");
  AST_ON_LEN: assert property (sFall |-> cfgSeen || runLen == 2 * OFF_CYC)
    else $error("on phase length");
  AST_OFF_LEN: assert property (sRise |-> cfgSeen || !ranOn || runLen == OFF_CYC)
    else $error("off phase length");
  AST_ON_COLOR: assert property (onPhase && !$past(cfgLoad) |->
    rgb == LUT[onCol*3 +: 3]) else $error("on colour");
  AST_OFF_COLOR: assert property (!onPhase && !$past(cfgLoad) |->
    rgb == LUT[offCol*3 +: 3]) else $error("off colour");
  AST_RGB_HOLD: assert property ($stable(onPhase) && !$past(cfgLoad) &&
    !$past(cfgLoad, 2) |-> $stable(rgb)) else $error("colour moved in phase");
endmodule

// *** dv/bbcs_led_model.sv ***
`timescale 1ns/1ps
module bbcs_led_model (
  // clock
  input  logic        clk_sys,
  // backlight lines
  input  logic        ledRed,
  input  logic        ledGreen,
  input  logic        ledBlue,
  input  logic        onPhase,
  // run report
  output logic        runDone,
  output logic        runOn,
  output logic [31:0] runLen,
  output logic [2:0]  runRgb
);
  logic [31:0] cnt = 32'h0;
  logic        last = 1'b0;
  logic [2:0]  rgb = 3'h0;
  // reports each finished run: length, phase and its final colour
  always @(posedge clk_sys) begin
    runDone <= onPhase != last;
    if (onPhase != last) begin
      {runLen, runOn, runRgb} <= {cnt, last, rgb};
      cnt <= 32'h1;
    end else
      cnt <= cnt + 32'h1;
    last <= onPhase;
    rgb <= {ledRed, ledGreen, ledBlue};
  end
endmodule

// *** dv/tb_backlight_blink_color_sequencer.sv ***
`timescale 1ns/1ps
module tb_backlight_blink_color_sequencer;
  logic        clk_sys = 0, rst = 1, cfgLoad = 0;
  logic [31:0] cfgOffLen = 0;
  logic [3:0]  cfgMult = 0;
  logic [2:0]  cfgOnColor = 0, cfgOffColor = 0;
  wire         ledRed, ledGreen, ledBlue, onPhase, runDone, runOn;
  wire  [31:0] runLen;
  wire  [2:0]  runRgb;
  int          mismatches = 0, n_checks = 0;
  localparam [23:0] LUT = 24'hf5e2a0;
  always #20 clk_sys = ~clk_sys;
  bbcs_sequencer #(.OFF_CYC(10)) dut (.clk_sys(clk_sys), .rst(rst),
    .cfgLoad(cfgLoad), .cfgOffLen(cfgOffLen), .cfgMult(cfgMult),
    .cfgOnColor(cfgOnColor), .cfgOffColor(cfgOffColor), .ledRed(ledRed),
    .ledGreen(ledGreen), .ledBlue(ledBlue), .onPhase(onPhase));
  bbcs_led_model model (.clk_sys(clk_sys), .ledRed(ledRed),
    .ledGreen(ledGreen), .ledBlue(ledBlue), .onPhase(onPhase),
    .runDone(runDone), .runOn(runOn), .runLen(runLen), .runRgb(runRgb));
  task final_report;
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task next_run;
    int i;
    i = 0;
    do begin @(negedge clk_sys); i++; end while (runDone !== 1'b1 && i < 200);
    if (i >= 200) begin
      mismatches++;
      $display("[FAIL] %0t no phase change", $time);
      final_report;
    end
  endtask
  task check_pair(input [31:0] onL, offL, input [2:0] onC, offC);
    repeat (2) begin
      next_run;
      n_checks++;
      if (runLen !== (runOn ? onL : offL) || runRgb !== (runOn ? onC : offC))
      begin
        mismatches++;
        $display("[FAIL] %0t run %0d rgb %h", $time, runLen, runRgb);
      end
    end
  endtask
  task t_defaults;
    rst = 1;
    repeat (3) @(negedge clk_sys);
    rst = 0;
    next_run;
    check_pair(20, 10, 3'h7, 3'h0);
  endtask
  task t_colors;
    for (int c = 0; c < 8; c++) begin
      {cfgOffLen, cfgMult, cfgOnColor, cfgOffColor} = {32'h3, c[3:0], c[2:0],
        3'(7 - c)};
      cfgLoad = 1;
      @(negedge clk_sys);
      cfgLoad = 0;
      // runs cut by the load are skipped; mult 0 counts as 1
      repeat (2) next_run;
      check_pair(3 * (c ? c : 1), 3, LUT[c*3 +: 3], LUT[(7-c)*3 +: 3]);
    end
  endtask
  initial begin
    t_defaults;
    t_colors;
    t_defaults;
    final_report;
  end
endmodule
bind bbcs_sequencer bbcs_properties #(.OFF_CYC(OFF_CYC)) chk (.clk_sys(clk_sys),
  .rst(rst), .cfgLoad(cfgLoad), .cfgOnColor(cfgOnColor),
  .cfgOffColor(cfgOffColor), .ledRed(ledRed), .ledGreen(ledGreen),
  .ledBlue(ledBlue), .onPhase(onPhase));
